// file: verilog/lamt_defines.vh
`ifndef LAMT_DEFINES_VH
`define LAMT_DEFINES_VH
// register indices; byte address is four times the index
`define LAMT_IDX_STATUS 4'h1
`define LAMT_IDX_CONFIG 4'h2
`define LAMT_IDX_UNDER 4'h3
`define LAMT_IDX_OVER 4'h4
`define LAMT_IDX_MARGIN 4'h5
`define LAMT_IDX_MIN 4'h6
`define LAMT_IDX_IRQ_MASK 4'h8
`define LAMT_IDX_CONV_DATA 4'h9
// status / mask bit positions
`define LAMT_BIT_UNDER 0
`define LAMT_BIT_OVER 1
// configuration fields
`define LAMT_CFG_HOLD 4
`define LAMT_CFG_CYC_HI 7
`define LAMT_CFG_CYC_LO 5
`define LAMT_CFG_MASK 8'hf5
// reset values
`define LAMT_RST_UNDER 12'h000
`define LAMT_RST_OVER 12'hfff
`define LAMT_RST_MARGIN 12'h000
`define LAMT_RST_MIN 12'hfff
`define LAMT_RST_CONFIG 8'h00
// conversion time unit in ns, and its cycle count at 50 MHz (20 ns)
`define LAMT_TCONV_NS 1000
`define LAMT_CLK_NS 20
`define LAMT_TCONV_CYC (`LAMT_TCONV_NS / `LAMT_CLK_NS)
`endif

// file: verilog/lamt_alert_flag.v
`timescale 1ns/10ps
`include "lamt_defines.vh"
// one sticky alert flag with hysteresis-based self-clear
module lamt_alert_flag
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // events
    input wire trip_i,
    input wire release_i,
    input wire hold_i,
    input wire sw_clear_i,
    // state
    output reg flag_o
);

always @(posedge clk_i)
begin
    if (rst_i)
        flag_o <= 1'b0;
    else if (trip_i)
        flag_o <= 1'b1;
    else if (sw_clear_i)
        flag_o <= 1'b0;
    else if (release_i && !hold_i)
        flag_o <= 1'b0;
end

endmodule // lamt_alert_flag

// file: verilog/lamt_conv_timer.v
`timescale 1ns/10ps
`include "lamt_defines.vh"
// produces one-cycle pulses spaced by conversion time times 2^(4+cycle)
module lamt_conv_timer
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // control
    input wire [2:0] cycle_i,
    // output
    output reg tick_o
);

reg [5:0] unit_cnt;
reg [10:0] slot_cnt;
wire unit_tick;
wire [10:0] slot_last;

// last count of one conversion-time unit, kept as an integer so the slice is explicit
localparam integer UNIT_LAST = `LAMT_TCONV_CYC - 1;

assign unit_tick = (unit_cnt == UNIT_LAST[5:0]);
assign slot_last = (cycle_i == 3'd0) ? 11'd0 : ((11'd16 << cycle_i) - 11'd1);

always @(posedge clk_i)
begin
    if (rst_i || cycle_i == 3'd0)
    begin
        unit_cnt <= 6'd0;
        slot_cnt <= 11'd0;
        tick_o <= 1'b0;
    end
    else
    begin
        tick_o <= 1'b0;
        if (unit_tick)
        begin
            unit_cnt <= 6'd0;
            if (slot_cnt >= slot_last)
            begin
                slot_cnt <= 11'd0;
                tick_o <= 1'b1;
            end
            else
                slot_cnt <= slot_cnt + 11'd1;
        end
        else
            unit_cnt <= unit_cnt + 6'd1;
    end
end

endmodule // lamt_conv_timer

// file: verilog/lamt_tracker.v
`timescale 1ns/10ps
`include "lamt_defines.vh"
module lamt_tracker
(
    // system
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // converter core
    input wire conv_valid_i,
    input wire [11:0] conv_data_i,
    output wire auto_conv_o,
    output wire auto_tick_o,
    // interrupt
    output wire irq_o
);

reg [11:0] under_range_threshold;
reg [11:0] over_range_threshold;
reg [11:0] alert_clear_margin;
reg [11:0] smallest_result_seen;
reg [7:0] config_reg;
reg [1:0] irq_mask;
reg [11:0] last_result;
reg [31:0] next_dat;
wire [1:0] alert_flag;
wire [1:0] trip;
wire [1:0] release_ok;
wire [1:0] sw_clear;
wire [3:0] idx;
wire req;
wire wr;
wire hold;
wire tick;
wire [12:0] under_plus;
wire [12:0] over_minus;
// one write strobe per writable register index; the conversion data index has none
wire wr_status;
wire wr_config;
wire wr_under;
wire wr_over;
wire wr_margin;
wire wr_min;
wire wr_mask;
wire rd_req;
// comparator outcomes for the current result
wire below_under;
wire above_over;
wire over_has_room;
wire clear_of_under;
wire clear_of_over;
wire lower_than_min;
wire [1:0] pending;
wire [2:0] cycle_sel;

assign idx = adr_i[5:2];
assign req = cyc_i && stb_i && !ack_o;
assign wr = req && we_i && sel_i[0];
assign rd_req = req && !we_i;
assign hold = config_reg[`LAMT_CFG_HOLD];
assign cycle_sel = config_reg[`LAMT_CFG_CYC_HI:`LAMT_CFG_CYC_LO];
assign auto_conv_o = |cycle_sel;

// decode once so every register process tests a single strobe
assign wr_status = wr && (idx == `LAMT_IDX_STATUS);
assign wr_config = wr && (idx == `LAMT_IDX_CONFIG);
assign wr_under = wr && (idx == `LAMT_IDX_UNDER);
assign wr_over = wr && (idx == `LAMT_IDX_OVER);
assign wr_margin = wr && (idx == `LAMT_IDX_MARGIN);
assign wr_min = wr && (idx == `LAMT_IDX_MIN);
assign wr_mask = wr && (idx == `LAMT_IDX_IRQ_MASK);

lamt_conv_timer u_timer
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cycle_i(cycle_sel),
    .tick_o(tick)
);
assign auto_tick_o = tick;

// widened sums so a threshold near the rails cannot wrap
assign under_plus = {1'b0, under_range_threshold} + {1'b0, alert_clear_margin};
assign over_minus = {1'b0, over_range_threshold} - {1'b0, alert_clear_margin};

assign below_under = conv_data_i < under_range_threshold;
assign above_over = conv_data_i > over_range_threshold;
// an over threshold below the margin leaves no band to fall back into
assign over_has_room = !over_minus[12];
assign clear_of_under = {1'b0, conv_data_i} > under_plus;
assign clear_of_over = over_has_room && ({1'b0, conv_data_i} < over_minus);
assign lower_than_min = conv_data_i < smallest_result_seen;

assign trip[`LAMT_BIT_UNDER] = conv_valid_i && below_under;
assign trip[`LAMT_BIT_OVER] = conv_valid_i && above_over;
assign release_ok[`LAMT_BIT_UNDER] = conv_valid_i && clear_of_under;
assign release_ok[`LAMT_BIT_OVER] = conv_valid_i && clear_of_over;

genvar g;
generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_flag
        // write-one-to-clear; a same-cycle trip wins inside the flag
        assign sw_clear[g] = wr_status && dat_i[g];
        lamt_alert_flag u_flag
        (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .trip_i(trip[g]),
            .release_i(release_ok[g]),
            .hold_i(hold),
            .sw_clear_i(sw_clear[g]),
            .flag_o(alert_flag[g])
        );
    end
endgenerate

assign pending = alert_flag & irq_mask;
assign irq_o = |pending;

// upper data bits are never stored, so bits 15:12 always read zero
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        under_range_threshold <= `LAMT_RST_UNDER;
    end
    else if (wr_under)
    begin
        under_range_threshold <= dat_i[11:0];
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        over_range_threshold <= `LAMT_RST_OVER;
    end
    else if (wr_over)
    begin
        over_range_threshold <= dat_i[11:0];
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        alert_clear_margin <= `LAMT_RST_MARGIN;
    end
    else if (wr_margin)
    begin
        alert_clear_margin <= dat_i[11:0];
    end
end

// configuration bits 1 and 3 are masked off so they read back zero; bits 0 and 2 are stored
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        config_reg <= `LAMT_RST_CONFIG;
    end
    else if (wr_config)
    begin
        config_reg <= dat_i[7:0] & `LAMT_CFG_MASK;
    end
end

always @(posedge clk_i)
begin
    if (rst_i)
    begin
        irq_mask <= 2'h0;
    end
    else if (wr_mask)
    begin
        irq_mask <= dat_i[1:0];
    end
end

// last result is read-only; host writes to its index are ignored
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        last_result <= 12'h000;
    end
    else if (conv_valid_i)
    begin
        last_result <= conv_data_i;
    end
end

// minimum tracking; a lower conversion in the same cycle as a host write wins
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        smallest_result_seen <= `LAMT_RST_MIN;
    end
    else if (conv_valid_i && lower_than_min)
    begin
        smallest_result_seen <= conv_data_i;
    end
    else if (wr_min)
    begin
        smallest_result_seen <= dat_i[11:0];
    end
end

always @*
begin
    next_dat = 32'h0000_0000;
    case (idx)
        `LAMT_IDX_STATUS:
        begin
            next_dat = {30'h0, alert_flag};
        end
        `LAMT_IDX_CONFIG:
        begin
            next_dat = {24'h0, config_reg};
        end
        `LAMT_IDX_UNDER:
        begin
            next_dat = {20'h0, under_range_threshold};
        end
        `LAMT_IDX_OVER:
        begin
            next_dat = {20'h0, over_range_threshold};
        end
        `LAMT_IDX_MARGIN:
        begin
            next_dat = {20'h0, alert_clear_margin};
        end
        `LAMT_IDX_MIN:
        begin
            next_dat = {20'h0, smallest_result_seen};
        end
        `LAMT_IDX_IRQ_MASK:
        begin
            next_dat = {30'h0, irq_mask};
        end
        `LAMT_IDX_CONV_DATA:
        begin
            next_dat = {20'h0, last_result};
        end
        default:
        begin
            next_dat = 32'h0000_0000;
        end
    endcase
end

// one wait state: ack the cycle after the request is seen
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_o <= 1'b0;
    end
    else
    begin
        ack_o <= req;
    end
end

// read data holds until the next read; unmapped indices read zero
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        dat_o <= 32'h0000_0000;
    end
    else if (rd_req)
    begin
        dat_o <= next_dat;
    end
end

endmodule // lamt_tracker

// file: verification/lamt_asserts.sv
`timescale 1ns/10ps
module lamt_chk
(
    // bus
    input wire clk_i, input wire rst_i, input wire cyc_i, input wire stb_i,
    input wire we_i, input wire [31:0] dat_o, input wire ack_o,
    // core and irq
    input wire conv_valid_i, input wire auto_conv_o, input wire auto_tick_o, input wire irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_take_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("long ack");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
    read_upper_a: assert property (ack_o && !$past(we_i) |-> dat_o[31:12] == 20'h0)
        else $error("upper bits");
    irq_rise_a: assert property ($rose(irq_o) |-> $past(conv_valid_i) || ack_o)
        else $error("irq rise");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(conv_valid_i) || ack_o)
        else $error("irq fall");
    tick_mode_a: assert property (auto_tick_o |-> auto_conv_o) else $error("tick");
    tick_pulse_a: assert property (auto_tick_o |=> !auto_tick_o) else $error("tick");
    cover property (ack_o && $past(we_i));
    cover property ($fell(irq_o));
    cover property (auto_tick_o);
endmodule // lamt_chk
bind lamt_tracker lamt_chk u_chk (.*);

// file: verification/lamt_conv_model.sv
`timescale 1ns/10ps
module lamt_conv_model
(
    // request
    input wire clk_i,
    input wire start_i,
    input wire [11:0] value_i,
    // result
    output reg valid_o = 1'b0,
    output reg [11:0] data_o = 12'h000
);
    // idle data toggles so a stray sample never looks like a result
    always @(posedge clk_i)
    begin
        valid_o <= start_i;
        data_o <= start_i ? value_i : ~data_o;
    end
endmodule // lamt_conv_model

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0;
    reg [5:0] adr = 6'h00;
    reg [31:0] dat = 32'h0, q;
    reg [11:0] av = 12'h000;
    wire [31:0] dat_o;
    wire [11:0] cd;
    wire ack_o, cv, aconv, tick, irq;
    integer failures = 0, samples_checked = 0, n;
    lamt_tracker uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .conv_valid_i(cv),
        .conv_data_i(cd), .auto_conv_o(aconv), .auto_tick_o(tick), .irq_o(irq));
    lamt_conv_model core (.clk_i(clk_i), .start_i(go | tick), .value_i(av), .valid_o(cv),
        .data_o(cd));
    initial
        forever #10 clk_i = ~clk_i;
    task print_verdict;
    begin
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task chk(input [31:0] s, input [31:0] e);
    begin
        samples_checked = samples_checked + 1;
        if (s !== e)
        begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    end
    endtask
    task wb(input [3:0] i, input w, input [31:0] d);
    begin
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        dat <= d;
        @(posedge clk_i);
        for (n = 0; n < 20 && ack_o !== 1'b1; n = n + 1)
            @(posedge clk_i);
        q = dat_o;
        cyc <= 0;
        stb <= 0;
        if (n == 20)
            failures = failures + 1;
        @(posedge clk_i);
    end
    endtask
    task rd(input [3:0] i, input [31:0] e);
    begin
        wb(i, 0, 0);
        chk(q, e);
    end
    endtask
    // result lands in the model one edge later, then the tracker takes it
    task cnv(input [11:0] v);
    begin
        av <= v;
        go <= 1;
        @(posedge clk_i);
        go <= 0;
        repeat (3) @(posedge clk_i);
    end
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        rd(3, 0);
        rd(4, 32'hfff);
        rd(5, 0);
        rd(6, 32'hfff);
        rd(7, 0);
        wb(3, 1, 32'h100);
        wb(4, 1, 32'h800);
        wb(5, 1, 32'h010);
        wb(8, 1, 32'h3);
        rd(5, 32'h010);
        cnv(12'h0ff);
        rd(1, 1);
        chk(irq, 1);
        wb(8, 1, 32'h0);
        chk(irq, 0);
        wb(8, 1, 32'h3);
        rd(6, 32'h0ff);
        cnv(12'h110);
        rd(1, 1);
        cnv(12'h111);
        rd(1, 0);
        cnv(12'h801);
        rd(1, 2);
        wb(1, 1, 32'h2);
        rd(1, 0);
        wb(2, 1, 32'h10);
        rd(2, 32'h10);
        chk(aconv, 0);
        cnv(12'h0f0);
        cnv(12'h400);
        rd(1, 1);
        wb(1, 1, 32'h1);
        rd(1, 0);
        wb(6, 1, 32'hfff);
        rd(6, 32'hfff);
        cnv(12'h300);
        rd(6, 32'h300);
        av <= 12'h200;
        wb(2, 1, 32'h20);
        chk(aconv, 1);
        for (n = 0; n < 3000 && tick !== 1'b1; n = n + 1)
            @(posedge clk_i);
        if (n == 3000)
            failures = failures + 1;
        repeat (4) @(posedge clk_i);
        rd(6, 32'h200);
        print_verdict;
    end
endmodule // testbench
